// ### dsp_channel.sv
// one compare channel: match detection and dual-slope waveform bit
`timescale 1ns/1ps
`default_nettype none
`include "dsp_params.svh"

module dsp_channel (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire dsp_pkg::dsp_cnt_type cnt,
  input  wire logic [15:0]          cmp,
  input  wire logic [1:0]           mode,
  input  wire logic                 toggle_ok,
  output logic                      wave,
  output logic                      match
);
  import dsp_pkg::*;

  dsp_chan_state_type st;
  dsp_chan_state_type next_st;
  logic               hit;
  logic               inv;
  logic               base;

  // compare above top can never hit the counter
  assign hit = cnt.tick && (cnt.count == cmp) && (cmp <= cnt.top);
  assign inv = (mode == `DSP_OM_INV);

  always_comb begin
    next_st       = st;
    next_st.match = hit;
    base          = st.wave ^ inv;
    unique case (mode)
      `DSP_OM_TOGGLE: begin
        if (toggle_ok && hit) begin
          next_st.wave = ~st.wave;
        end
      end
      `DSP_OM_NONINV, `DSP_OM_INV: begin
        if (cnt.tick) begin
          // extremes pin the level instead of glitching at the turn
          if (cmp == `DSP_BOTTOM) begin
            base = 1'b0;
          end else if (cmp == cnt.top) begin
            base = 1'b1;
          end else if (hit) begin
            base = cnt.down;
          end
        end
        next_st.wave = base ^ inv;
      end
      default: next_st.wave = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wave  = st.wave;
  assign match = st.match;

endmodule // dsp_channel
`default_nettype wire

// ### dsp_load_model.sv
// pin load model: each pwm pin with a pull-down behind it
`timescale 1ns/1ps
`default_nettype none

module dsp_load_model (
  input  wire logic [1:0] wave,
  input  wire logic [1:0] oe,
  output logic [1:0]      pin
);
  // an undriven pin falls to the pull-down, never the last driven level
  assign pin[0] = oe[0] ? wave[0] : 1'b0;
  assign pin[1] = oe[1] ? wave[1] : 1'b0;
endmodule // dsp_load_model

`default_nettype wire

// ### dsp_params.svh
// constants of the dual-slope pwm timer: offsets, fields, reset values, counts
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH

// register byte offsets
`define DSP_OFS_CTRL      8'h00
`define DSP_OFS_COUNT     8'h04
`define DSP_OFS_CMP_A     8'h08
`define DSP_OFS_CMP_B     8'h0C
`define DSP_OFS_CAP_TOP   8'h10
`define DSP_OFS_INT_STAT  8'h14
`define DSP_OFS_INT_MASK  8'h18
`define DSP_OFS_STATUS    8'h1C

// control field positions
`define DSP_CTRL_WGM_LSB   0
`define DSP_CTRL_CS_LSB    4
`define DSP_CTRL_MODEA_LSB 8
`define DSP_CTRL_MODEB_LSB 10
`define DSP_CTRL_DIRA_BIT  12
`define DSP_CTRL_DIRB_BIT  13

// reset values
`define DSP_RST_WORD16   16'h0000
`define DSP_RST_FLAGS    3'h0
`define DSP_RST_DATA     32'h0000_0000

// waveform generation codes
`define DSP_WGM_PC8      4'h1
`define DSP_WGM_PC9      4'h2
`define DSP_WGM_PC10     4'h3
`define DSP_WGM_PFC_CAP  4'h8
`define DSP_WGM_PFC_CMPA 4'h9
`define DSP_WGM_PC_CAP   4'hA
`define DSP_WGM_PC_CMPA  4'hB

// fixed and limit tops
`define DSP_TOP_8BIT     16'h00FF
`define DSP_TOP_9BIT     16'h01FF
`define DSP_TOP_10BIT    16'h03FF
`define DSP_TOP_MIN      16'h0003
`define DSP_BOTTOM       16'h0000

// channel output mode codes
`define DSP_OM_OFF       2'h0
`define DSP_OM_TOGGLE    2'h1
`define DSP_OM_NONINV    2'h2
`define DSP_OM_INV       2'h3

// clock select codes and prescaler terminal counts (divider minus one)
`define DSP_CS_STOP      3'h0
`define DSP_CS_DIV1      3'h1
`define DSP_CS_DIV8      3'h2
`define DSP_CS_DIV64     3'h3
`define DSP_CS_DIV256    3'h4
`define DSP_CS_DIV1024   3'h5
`define DSP_TC_DIV1      10'h000
`define DSP_TC_DIV8      10'h007
`define DSP_TC_DIV64     10'h03F
`define DSP_TC_DIV256    10'h0FF
`define DSP_TC_DIV1024   10'h3FF

`endif

// ### dsp_pkg.sv
// types shared by the dual-slope pwm timer modules
package dsp_pkg;

  // software control fields
  typedef struct packed {
    logic [1:0]      pin_direction_bit;
    logic [1:0][1:0] channel_output_mode;
    logic [2:0]      clk_sel;
    logic [3:0]      waveform_gen_select;
  } dsp_ctrl_type;

  // counter view handed to every channel
  typedef struct packed {
    logic        tick;
    logic        down;
    logic [15:0] count;
    logic [15:0] top;
  } dsp_cnt_type;

  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } dsp_psc_state_type;

  typedef struct packed {
    logic wave;
    logic match;
  } dsp_chan_state_type;

  typedef struct packed {
    dsp_ctrl_type     ctrl;
    logic [1:0][15:0] cmp_buf;
    logic [1:0][15:0] cmp_act;
    logic [15:0]      capture_top_value;
    logic [15:0]      counter_value;
    logic             down;
    logic [2:0]       int_status;
    logic [2:0]       int_mask;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq;
    logic [1:0]       pin_out;
    logic [1:0]       pin_oe;
  } dsp_state_type;

endpackage

// ### dsp_prescaler.sv
// prescaler: one-cycle timer tick at clk divided by 1, 8, 64, 256 or 1024
`timescale 1ns/1ps
`default_nettype none
`include "dsp_params.svh"

module dsp_prescaler (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] sel,
  output logic            tick
);
  import dsp_pkg::*;

  dsp_psc_state_type st;
  dsp_psc_state_type next_st;
  logic [9:0]        term;

  // divider choice, stop code gives no tick
  always_comb begin
    next_st = st;
    term    = `DSP_TC_DIV1;
    unique case (sel)
      `DSP_CS_DIV8:    term = `DSP_TC_DIV8;
      `DSP_CS_DIV64:   term = `DSP_TC_DIV64;
      `DSP_CS_DIV256:  term = `DSP_TC_DIV256;
      `DSP_CS_DIV1024: term = `DSP_TC_DIV1024;
      default:         term = `DSP_TC_DIV1;
    endcase
    if (sel == `DSP_CS_STOP || sel > `DSP_CS_DIV1024) begin
      next_st.cnt  = 10'h000;
      next_st.tick = 1'b0;
    end else if (st.cnt >= term) begin
      next_st.cnt  = 10'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt  = 10'(st.cnt + 10'h001);
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  AST_DIV8_SPACING: assert property (@(posedge clk) disable iff (!nrst)
    (tick && sel == `DSP_CS_DIV8) ##1 (sel == `DSP_CS_DIV8) [*8] |-> tick)
    else $error("divide by 8 tick spacing wrong");

endmodule // dsp_prescaler
`default_nettype wire

// ### dsp_timer.sv
// dual-slope 16-bit pwm timer with apb registers, two channels, interrupt
//
// Overview of operation
// - keep top at or above compares; a compare above top never matches.
// - fixed-top modes mask unused compare bits to zero on every write.
// - phase correct mode loads active compares from buffers at top.
// - phase correct top change: falling slope old top, rising slope new.
// - dual-slope output code two is non-inverted, three is inverted.
// - waveform drives its pin only when its direction bit selects output.
// - non-inverted: clear on up-count match, set on down-count match.
// - timer tick from clk divided by 1, 8, 64, 256 or 1024.
// - non-inverted: compare at bottom gives constant low, at top constant high.
// - mode 11 with channel a code one toggles the output, 50% duty.
// - modes 8 and 9 select phase and frequency correct pwm.
// - counter climbs from zero to top, then descends back to zero.
// - top is capture register in mode 8, compare a in mode 9.
// - top register holds at least 3; full 16-bit range allowed.
// - counter stays at top for exactly one timer tick before descending.
// - each compare match sets that channel's interrupt flag.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_params.svh"

module dsp_timer (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [1:0]       channel_waveform_out,
  output logic [1:0]       channel_waveform_oe,
  output logic             irq
);
  import dsp_pkg::*;

  dsp_state_type st;
  dsp_state_type next_st;
  dsp_cnt_type   cnt;
  logic          tick;
  logic [1:0]    chan_wave;
  logic [1:0]    chan_match;
  logic          dual;
  logic          pfc;
  logic          fixed_top;
  logic [15:0]   raw_top;
  logic [15:0]   top;
  logic          wr;
  logic          setup;
  logic          at_top;
  logic          at_bottom;
  logic [1:0]    connected;
  logic [2:0]    events;

  dsp_prescaler u_prescaler (
    .clk  (clk),
    .nrst (nrst),
    .sel  (st.ctrl.clk_sel),
    .tick (tick)
  );

  // mode decode and top choice
  always_comb begin
    dual      = 1'b1;
    pfc       = 1'b0;
    fixed_top = 1'b0;
    raw_top   = `DSP_TOP_8BIT;
    unique case (st.ctrl.waveform_gen_select)
      `DSP_WGM_PC8: begin
        fixed_top = 1'b1;
      end
      `DSP_WGM_PC9: begin
        fixed_top = 1'b1;
        raw_top   = `DSP_TOP_9BIT;
      end
      `DSP_WGM_PC10: begin
        fixed_top = 1'b1;
        raw_top   = `DSP_TOP_10BIT;
      end
      `DSP_WGM_PFC_CAP: begin
        pfc     = 1'b1;
        raw_top = st.capture_top_value;
      end
      `DSP_WGM_PFC_CMPA: begin
        pfc     = 1'b1;
        raw_top = st.cmp_act[0];
      end
      `DSP_WGM_PC_CAP:  raw_top = st.capture_top_value;
      `DSP_WGM_PC_CMPA: raw_top = st.cmp_act[0];
      default:          dual    = 1'b0;
    endcase
    // a top below the floor of 3 would stall the turn logic
    top = (raw_top < `DSP_TOP_MIN) ? `DSP_TOP_MIN : raw_top;
  end

  assign at_top    = tick && dual && !st.down && (st.counter_value >= top);
  assign at_bottom = tick && dual && st.down && (st.counter_value == `DSP_BOTTOM);
  assign setup     = psel && !penable;
  assign wr        = psel && penable && pwrite && st.pready;

  // counter view shared by both channels
  assign cnt.tick  = tick && dual;
  assign cnt.down  = st.down;
  assign cnt.count = st.counter_value;
  assign cnt.top   = top;

  // one compare unit per channel; toggle only on channel a with compare-a top
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      dsp_channel u_chan (
        .clk       (clk),
        .nrst      (nrst),
        .cnt       (cnt),
        .cmp       (st.cmp_act[gi]),
        .mode      (st.ctrl.channel_output_mode[gi]),
        .toggle_ok (gi == 0 && st.ctrl.waveform_gen_select == `DSP_WGM_PC_CMPA),
        .wave      (chan_wave[gi]),
        .match     (chan_match[gi])
      );
      assign connected[gi] = (st.ctrl.channel_output_mode[gi] == `DSP_OM_NONINV)
                          || (st.ctrl.channel_output_mode[gi] == `DSP_OM_INV)
                          || (gi == 0 && st.ctrl.channel_output_mode[gi] == `DSP_OM_TOGGLE
                              && st.ctrl.waveform_gen_select == `DSP_WGM_PC_CMPA);
    end
  endgenerate

  assign events = {at_bottom, chan_match};

  // counter, buffers, registers and bus answer
  always_comb begin
    next_st = st;
    // dual-slope count with one tick held at top and bottom
    if (!dual) begin
      next_st.counter_value = `DSP_BOTTOM;
      next_st.down          = 1'b0;
      next_st.cmp_act       = st.cmp_buf;
    end else if (at_top) begin
      next_st.down          = 1'b1;
      next_st.counter_value = 16'(st.counter_value - 16'h0001);
      if (!pfc) begin
        next_st.cmp_act = st.cmp_buf;
      end
    end else if (at_bottom) begin
      next_st.down          = 1'b0;
      next_st.counter_value = 16'(st.counter_value + 16'h0001);
      if (pfc) begin
        next_st.cmp_act = st.cmp_buf;
      end
    end else if (tick) begin
      next_st.counter_value = st.down ? 16'(st.counter_value - 16'h0001)
                                      : 16'(st.counter_value + 16'h0001);
    end
    // sticky flags, a new event beats a write-one clear
    next_st.int_status = st.int_status & ~((wr && paddr == `DSP_OFS_INT_STAT) ? pwdata[2:0] : 3'h0);
    next_st.int_status = next_st.int_status | events;
    // register writes take effect at the completing access edge
    if (wr) begin
      unique case (paddr)
        `DSP_OFS_CTRL: begin
          next_st.ctrl.waveform_gen_select    = pwdata[`DSP_CTRL_WGM_LSB +: 4];
          next_st.ctrl.clk_sel                = pwdata[`DSP_CTRL_CS_LSB +: 3];
          next_st.ctrl.channel_output_mode[0] = pwdata[`DSP_CTRL_MODEA_LSB +: 2];
          next_st.ctrl.channel_output_mode[1] = pwdata[`DSP_CTRL_MODEB_LSB +: 2];
          next_st.ctrl.pin_direction_bit      = {pwdata[`DSP_CTRL_DIRB_BIT], pwdata[`DSP_CTRL_DIRA_BIT]};
        end
        `DSP_OFS_CMP_A: next_st.cmp_buf[0] = fixed_top ? (pwdata[15:0] & raw_top) : pwdata[15:0];
        `DSP_OFS_CMP_B: next_st.cmp_buf[1] = fixed_top ? (pwdata[15:0] & raw_top) : pwdata[15:0];
        `DSP_OFS_CAP_TOP:  next_st.capture_top_value = pwdata[15:0];
        `DSP_OFS_INT_MASK: next_st.int_mask          = pwdata[2:0];
        default: ;
      endcase
    end
    // zero-wait answer: data and ready are loaded in the setup cycle
    next_st.pready  = setup;
    next_st.pslverr = 1'b0;
    next_st.prdata  = `DSP_RST_DATA;
    if (setup) begin
      unique case (paddr)
        `DSP_OFS_CTRL: next_st.prdata = {18'h00000, st.ctrl.pin_direction_bit,
                                         st.ctrl.channel_output_mode[1], st.ctrl.channel_output_mode[0],
                                         1'b0, st.ctrl.clk_sel, st.ctrl.waveform_gen_select};
        `DSP_OFS_COUNT:    next_st.prdata = {16'h0000, st.counter_value};
        `DSP_OFS_CMP_A:    next_st.prdata = {16'h0000, st.cmp_buf[0]};
        `DSP_OFS_CMP_B:    next_st.prdata = {16'h0000, st.cmp_buf[1]};
        `DSP_OFS_CAP_TOP:  next_st.prdata = {16'h0000, st.capture_top_value};
        `DSP_OFS_INT_STAT: next_st.prdata = {29'h00000000, st.int_status};
        `DSP_OFS_INT_MASK: next_st.prdata = {29'h00000000, st.int_mask};
        `DSP_OFS_STATUS:   next_st.prdata = {30'h00000000, dual, st.down};
        default:           next_st.pslverr = 1'b1;
      endcase
    end
    // pins only driven when the direction bit asks for output
    next_st.pin_out = chan_wave & connected;
    next_st.pin_oe  = st.ctrl.pin_direction_bit & connected;
    next_st.irq     = |(st.int_status & st.int_mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata               = st.prdata;
  assign pready               = st.pready;
  assign pslverr              = st.pslverr;
  assign channel_waveform_out = st.pin_out;
  assign channel_waveform_oe  = st.pin_oe;
  assign irq                  = st.irq;

  // checks
  default clocking dck @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_TOP_TURN: assert property (
    at_top |=> st.down && st.counter_value == $past(st.counter_value) - 16'h0001)
    else $error("counter did not turn after one tick at top");

  AST_BOTTOM_TURN: assert property (
    at_bottom |=> !st.down && st.counter_value == 16'h0001)
    else $error("counter did not climb again from bottom");

  AST_PC_LOAD_AT_TOP: assert property (
    at_top && !pfc |=> st.cmp_act == $past(st.cmp_buf))
    else $error("phase correct compare not loaded at top");

  AST_PFC_LOAD_AT_BOTTOM: assert property (
    at_bottom && pfc |=> st.cmp_act == $past(st.cmp_buf))
    else $error("frequency correct compare not loaded at bottom");

  AST_PFC_HOLD_AT_TOP: assert property (
    at_top && pfc |=> st.cmp_act == $past(st.cmp_act))
    else $error("frequency correct compare changed at top");

  AST_FIXED_MASK: assert property (
    wr && paddr == `DSP_OFS_CMP_A && st.ctrl.waveform_gen_select == `DSP_WGM_PC8 |=> st.cmp_buf[0][15:8] == 8'h00)
    else $error("unused compare bits not masked");

  AST_MATCH_ABOVE_TOP: assert property (
    chan_match[0] |-> $past(st.cmp_act[0]) <= $past(top))
    else $error("match with compare above top");

  AST_MATCH_FLAG: assert property (
    chan_match[1] |=> st.int_status[1])
    else $error("match did not set its flag");

  AST_PIN_DIR: assert property (
    !st.ctrl.pin_direction_bit[0] ##1 !st.ctrl.pin_direction_bit[0] |-> !channel_waveform_oe[0])
    else $error("pin driven without direction bit");

  AST_BOTTOM_LOW: assert property (
    cnt.tick && st.ctrl.channel_output_mode[0] == `DSP_OM_NONINV && st.cmp_act[0] == `DSP_BOTTOM
      |=> !chan_wave[0])
    else $error("compare at bottom did not hold output low");

  AST_UP_CLEAR: assert property (
    cnt.tick && !st.down && st.ctrl.channel_output_mode[1] == `DSP_OM_NONINV
      && st.counter_value == st.cmp_act[1] && st.cmp_act[1] != `DSP_BOTTOM && st.cmp_act[1] < top
      |=> !chan_wave[1])
    else $error("non-inverted output not cleared on up match");

  AST_TOGGLE: assert property (
    chan_match[0] && st.ctrl.waveform_gen_select == `DSP_WGM_PC_CMPA
      && st.ctrl.channel_output_mode[0] == `DSP_OM_TOGGLE && $stable(st.ctrl)
      |-> chan_wave[0] != $past(chan_wave[0]))
    else $error("toggle mode did not toggle");

  AST_PFC_TOP_CAP: assert property (
    st.ctrl.waveform_gen_select == `DSP_WGM_PFC_CAP && st.capture_top_value >= `DSP_TOP_MIN
      |-> top == st.capture_top_value)
    else $error("capture register not used as top");

  AST_IRQ: assert property (
    |(st.int_status & st.int_mask) |=> irq)
    else $error("unmasked flag did not raise interrupt");

  AST_PC_NEW_TOP: assert property (
    at_top && st.ctrl.waveform_gen_select == `DSP_WGM_PC_CMPA && st.cmp_buf[0] >= `DSP_TOP_MIN && !wr
      |=> top == $past(st.cmp_buf[0]))
    else $error("rising slope not on new top");

  AST_PFC_SELECT: assert property (
    st.ctrl.waveform_gen_select == `DSP_WGM_PFC_CAP || st.ctrl.waveform_gen_select == `DSP_WGM_PFC_CMPA
      |-> pfc && dual)
    else $error("frequency correct mode not selected");

  AST_PC_HOLD_AT_BOTTOM: assert property (
    at_bottom && !pfc |=> st.cmp_act == $past(st.cmp_act))
    else $error("phase correct compare changed at bottom");

  AST_PFC_TOP_CMPA: assert property (
    st.ctrl.waveform_gen_select == `DSP_WGM_PFC_CMPA && st.cmp_act[0] >= `DSP_TOP_MIN
      |-> top == st.cmp_act[0])
    else $error("compare a not used as top");

  AST_DOWN_SET: assert property (
    cnt.tick && st.down && st.ctrl.channel_output_mode[1] == `DSP_OM_NONINV
      && st.counter_value == st.cmp_act[1] && st.cmp_act[1] != `DSP_BOTTOM && st.cmp_act[1] < top
      |=> chan_wave[1])
    else $error("non-inverted output not set on down match");

  AST_INV_UP_SET: assert property (
    cnt.tick && !st.down && st.ctrl.channel_output_mode[1] == `DSP_OM_INV
      && st.counter_value == st.cmp_act[1] && st.cmp_act[1] != `DSP_BOTTOM && st.cmp_act[1] < top
      |=> chan_wave[1])
    else $error("inverted output not set on up match");

  AST_TOP_HIGH: assert property (
    cnt.tick && st.ctrl.channel_output_mode[0] == `DSP_OM_NONINV && st.cmp_act[0] == top
      |=> chan_wave[0])
    else $error("compare at top did not hold output high");

  AST_HOLD_NO_TICK: assert property (
    dual && !tick |=> st.counter_value == $past(st.counter_value))
    else $error("counter moved without a tick");

  AST_STOP_NO_TICK: assert property (
    st.ctrl.clk_sel == `DSP_CS_STOP |=> !tick)
    else $error("tick while clock stopped");

  AST_DIV1_TICK: assert property (
    st.ctrl.clk_sel == `DSP_CS_DIV1 |=> tick)
    else $error("undivided clock missed a tick");

  AST_MATCH_FLAG_A: assert property (
    chan_match[0] |=> st.int_status[0])
    else $error("channel a match did not set its flag");

  AST_OE_DIR_B: assert property (
    channel_waveform_oe[1] |-> $past(st.ctrl.pin_direction_bit[1]))
    else $error("channel b pin driven without direction bit");

  COV_PFC_BOTTOM: cover property (at_bottom && pfc);
  COV_PC_TOP: cover property (at_top && !pfc);
  COV_IRQ: cover property ($rose(irq));
  COV_TOGGLE: cover property (chan_match[0] && st.ctrl.channel_output_mode[0] == `DSP_OM_TOGGLE);
  COV_PC_NEW_TOP: cover property (at_top && !pfc && st.cmp_buf[0] != st.cmp_act[0]);

endmodule // dsp_timer
`default_nettype wire

// ### dual_slope_pwm_timer_tb.sv
// self-checking bench of the dual-slope pwm timer
`timescale 1ns/1ps
`default_nettype none
`include "dsp_params.svh"

module dual_slope_pwm_timer_tb;
  import dsp_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  wave, oe, pin;
  int          errors, n_checks, cyc, lo, hi, t, c, m, om;
  int          dv[5] = '{1, 8, 64, 256, 1024};
  int          md[4] = '{8, 9, 10, 11};

  dsp_timer uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_waveform_out(wave), .channel_waveform_oe(oe), .irq(irq));
  dsp_load_model load (.wave(wave), .oe(oe), .pin(pin));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard: the whole run needs far fewer cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      end_sim;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // one apb transfer; request stands until pready is seen high at a rising edge, data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk("pready", 32'(pready), 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // stop, load top and compares, then start with the given modes
  task automatic cfg(input int md_, cs, oa, ob, top, ca, cb, dr);
    apb(1'b1, `DSP_OFS_CTRL, 32'h0); // top only changes while stopped
    apb(1'b1, `DSP_OFS_CAP_TOP, 32'(top));
    apb(1'b1, `DSP_OFS_CMP_A, 32'(ca));
    apb(1'b1, `DSP_OFS_CMP_B, 32'(cb));
    apb(1'b1, `DSP_OFS_CTRL, 32'(md_ | (cs << `DSP_CTRL_CS_LSB) | (oa << `DSP_CTRL_MODEA_LSB)
        | (ob << `DSP_CTRL_MODEB_LSB) | (dr << `DSP_CTRL_DIRA_BIT)));
  endtask

  // skip to a falling edge, then time one low and one high pulse
  task automatic meas(input int ch);
    int k;
    k = 0;
    @(negedge clk);
    while (pin[ch] !== 1'b1 && k < 30000) begin @(negedge clk); k++; end
    while (pin[ch] !== 1'b0 && k < 30000) begin @(negedge clk); k++; end
    lo = 0;
    hi = 0;
    while (pin[ch] === 1'b0 && k < 30000) begin @(negedge clk); k++; lo++; end
    while (pin[ch] === 1'b1 && k < 30000) begin @(negedge clk); k++; hi++; end
    chk("pulse wait", 32'(k >= 30000), 32'h0);
  endtask

  // the pin must hold one level once settled
  task automatic lvl(input int ch, input logic exp);
    int k;
    k = 0;
    repeat (40) @(negedge clk);
    repeat (30) begin
      @(negedge clk);
      if (pin[ch] !== exp) k++;
    end
    chk("level", 32'(k), 32'h0);
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    t = $urandom(14812);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // every word reads zero after reset
    for (int a = 0; a < 32; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    // unmapped word answers with an error
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    chk("slverr", 32'(er), 32'h1);
    // fixed 8-bit top clips the compare on write
    apb(1'b1, `DSP_OFS_CTRL, 32'(`DSP_WGM_PC8));
    apb(1'b1, `DSP_OFS_CMP_A, 32'hFFFF);
    apb(1'b0, `DSP_OFS_CMP_A, 32'h0);
    chk("masked compare", rd, 32'h00FF);
    // each divider stretches the waveform by its ratio; top 3 is the least allowed
    for (int i = 0; i < 5; i++) begin
      cfg(8, i + 1, 2, 0, 3, 1, 0, 3);
      meas(0);
      chk("low width", 32'(lo), 32'(4 * dv[i]));
      chk("high width", 32'(hi), 32'(2 * dv[i]));
    end
    // fixed 8, 9 and 10 bit tops with compare 64 on channel b
    for (int i = 1; i < 4; i++) begin
      cfg(i, 1, 0, 2, 0, 0, 64, 3);
      meas(1);
      chk("fixed low", 32'(lo), 32'(2 * ((1 << (7 + i)) - 1 - 64)));
      chk("fixed high", 32'(hi), 32'd128);
    end
    // random tops and compares over the variable-top modes 8 to 11 on channel b
    repeat (6) begin
      m  = md[$urandom % 4];
      t  = 3 + $urandom % 14;
      c  = 1 + $urandom % (t - 1);
      om = 2 + $urandom % 2;
      cfg(m, 1, 0, om, t, (m == 9 || m == 11) ? t : 0, c, 3);
      meas(1);
      chk("low width", 32'(lo), 32'(2 * (om == 2 ? t - c : c)));
      chk("high width", 32'(hi), 32'(2 * (om == 2 ? c : t - c)));
    end
    // compare at bottom or top pins the output, inverted flips it
    for (int i = 0; i < 4; i++) begin
      cfg(10, 1, 2 + i % 2, 0, 7, (i / 2) * 7, 0, 3);
      lvl(0, 1'((i / 2) ^ (i % 2)));
    end
    // compare a as top with code one toggles at half duty
    cfg(11, 1, 1, 0, 3, 5, 0, 3);
    meas(0);
    chk("toggle low", 32'(lo), 32'd10);
    chk("toggle high", 32'(hi), 32'd10);
    // channel a without its direction bit stays off the pin
    cfg(8, 1, 2, 2, 3, 1, 1, 2);
    lvl(0, 1'b0);
    chk("enables", 32'(oe), 32'h2);
    // compare a above top never matches while channel b keeps flagging
    cfg(8, 1, 2, 2, 3, 5, 1, 3);
    apb(1'b1, `DSP_OFS_INT_STAT, 32'h7);
    repeat (40) @(posedge clk);
    apb(1'b1, `DSP_OFS_CTRL, 32'(`DSP_WGM_PFC_CAP));
    apb(1'b0, `DSP_OFS_INT_STAT, 32'h0);
    chk("match flags", rd & 32'h3, 32'h2);
    apb(1'b1, `DSP_OFS_INT_MASK, 32'h1);
    repeat (3) @(negedge clk);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, `DSP_OFS_INT_MASK, 32'h2);
    repeat (3) @(negedge clk);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b1, `DSP_OFS_INT_STAT, 32'h7);
    repeat (3) @(negedge clk);
    chk("irq cleared", 32'(irq), 32'h0);
    apb(1'b0, `DSP_OFS_INT_STAT, 32'h0);
    chk("flags cleared", rd, 32'h0);
    end_sim;
  end
endmodule // dual_slope_pwm_timer_tb

`default_nettype wire
